// ===== include/pce_pkg.sv
// Shared constants and types of the parallel checksum engine.
// Assumes a 32-bit peripheral bus with byte offsets inside one block.
package pce_pkg;

    // ********************************************************************
    // Bus widths and register offsets.
    // ********************************************************************
    localparam int          PCE_ADDR_W     = 8;        // Offset bits decoded.
    localparam int          PCE_DATA_W     = 32;       // Bus data width.
    localparam logic [7:0]  OFF_CONTROL    = 8'h00;    // checksum_control.
    localparam logic [7:0]  OFF_WORD       = 8'h04;    // word_input.
    localparam logic [7:0]  OFF_HALFWORD   = 8'h08;    // halfword_input.
    localparam logic [7:0]  OFF_BYTE       = 8'h0c;    // byte_input.
    localparam logic [7:0]  OFF_RESULT     = 8'h10;    // checksum_result.
    localparam logic [7:0]  OFF_SEED       = 8'h14;    // seed_preload.
    localparam logic [7:0]  OFF_PRIVATE    = 8'h18;    // vendor_private_byte.

    // ********************************************************************
    // Control field layout and reset values.
    // ********************************************************************
    localparam int          CTL_ENABLE_BIT = 0;        // Unit enable.
    localparam int          CTL_ORDER_BIT  = 2;        // input_bit_order.
    localparam int          CTL_WSEL_LO    = 4;        // width_select low.
    localparam int          CTL_WSEL_HI    = 6;        // width_select high.
    localparam logic [2:0]  WSEL_CRC16     = 3'h0;     // 16-bit checksum.
    localparam logic [2:0]  WSEL_CRC32     = 3'h1;     // 32-bit checksum.
    localparam logic [31:0] STATE_RESET    = 32'h0000ffff; // Result reset.
    localparam logic [31:0] ZERO_WORD      = 32'h00000000; // Plain zero.

    // ********************************************************************
    // Generator polynomials and step sizes.
    // ********************************************************************
    localparam logic [15:0] POLY16         = 16'h1021; // x^16+x^12+x^5+1.
    localparam logic [31:0] POLY32         = 32'h04c11db7; // Ethernet.
    localparam logic [5:0]  BITS_WORD      = 6'h20;    // 32 data bits.
    localparam logic [5:0]  BITS_HALF      = 6'h10;    // 16 data bits.
    localparam logic [5:0]  BITS_BYTE      = 6'h08;    // 8 data bits.
    localparam int          FIFO_DEPTH     = 16;       // Queue depth.

    // Kind of queued command.
    typedef enum logic [1:0] {
        KIND_WORD,
        KIND_HALF,
        KIND_BYTE,
        KIND_SEED
    } pce_kind_e;

    // One queued command: its kind and the written bus word.
    typedef struct packed {
        pce_kind_e   kind;
        logic [31:0] data;
    } pce_entry_s;

    localparam int          ENTRY_W        = $bits(pce_entry_s); // Width.

endpackage

// ===== include/pce_stream_if.sv
// Valid/ready stream carrier used between the engine's own modules.
// Assumes both ends share one clock; no timing is implied by the carrier.
`timescale 1ns/100ps
`default_nettype none

interface pce_stream_if #(
    parameter int W = 34                       // Payload width.
);
    logic         valid;                       // Payload present.
    logic         ready;                       // Sink takes it.
    logic [W-1:0] data;                        // Payload.

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ===== hdl/pce_fifo.sv
// Synchronous flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module pce_fifo #(
    parameter int WIDTH = 34,                  // Entry width.
    parameter int DEPTH = 16                   // Entry count.
) (
    input  wire logic clk,                     // System clock.
    input  wire logic srst,                    // Synchronous reset.
    pce_stream_if.snk fill,                    // Filling side.
    pce_stream_if.src drain                    // Draining side.
);
    localparam int PW = $clog2(DEPTH);         // Pointer width.
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH); // Full level.

    logic [WIDTH-1:0] memQ [DEPTH];            // Storage flops.
    logic [PW-1:0]    wrPtrQ, wrPtrD;          // Write index.
    logic [PW-1:0]    rdPtrQ, rdPtrD;          // Read index.
    logic [PW:0]      countQ, countD;          // Fill level.
    logic             doPush, doPop;           // Handshakes.

    // Full and empty come straight from the level, so both are honest.
    assign fill.ready  = (countQ != FULL_CNT);
    assign drain.valid = (countQ != '0);
    assign drain.data  = memQ[rdPtrQ];

    // Next pointers and level from the two handshakes.
    always_comb begin
        doPush = fill.valid & fill.ready;
        doPop  = drain.valid & drain.ready;
        wrPtrD = doPush ? wrPtrQ + PW'(1) : wrPtrQ;
        rdPtrD = doPop ? rdPtrQ + PW'(1) : rdPtrQ;
        countD = countQ + (PW+1)'(doPush) - (PW+1)'(doPop);
    end

    // Registers only; storage needs no reset since empty hides it.
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
        end else begin
            wrPtrQ <= wrPtrD;
            rdPtrQ <= rdPtrD;
            countQ <= countD;
        end
        if (doPush) begin
            memQ[wrPtrQ] <= fill.data;
        end
    end
endmodule

`default_nettype wire

// ===== hdl/pce_fold.sv
// Parallel checksum step: folds up to 32 data bits into a state at once.
// Assumes the caller picks how many low data bits count.
`timescale 1ns/100ps
`default_nettype none

module pce_fold #(
    parameter int             CRC_W = 32,           // State width.
    parameter logic [CRC_W-1:0] POLY = '0          // Generator taps.
) (
    input  wire logic [CRC_W-1:0] stateIn,     // Running checksum.
    input  wire logic [31:0]      dataIn,      // Written word.
    input  wire logic [5:0]       nBits,       // Bits to fold.
    output logic      [CRC_W-1:0] stateOut     // Folded checksum.
);
    // The loop unrolls into pure xor equations: one step, one cycle.
    // Data bit 0 enters first, whatever the selected bit order.
    always_comb begin
        logic [CRC_W-1:0] s;
        logic             fb;
        s  = stateIn;
        fb = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (6'(i) < nBits) begin
                fb = s[CRC_W-1] ^ dataIn[i];
                s  = {s[CRC_W-2:0], 1'b0} ^ (fb ? POLY : '0);
            end
        end
        stateOut = s;
    end
endmodule

`default_nettype wire

// ===== hdl/pce_core.sv
// Register-mapped parallel checksum engine on an APB slave port.
// Assumes APB3 signalling from the processor, one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none

module pce_core #(
    parameter int QUEUE_DEPTH = 16             // Command queue depth.
) (
    input  wire logic                        clk,     // System clock.
    input  wire logic                        srst,    // Sync reset, high.
    input  wire logic                        psel,    // Slave select.
    input  wire logic                        penable, // Access phase.
    input  wire logic                        pwrite,  // Write when high.
    input  wire logic [pce_pkg::PCE_ADDR_W-1:0] paddr, // Byte offset.
    input  wire logic [pce_pkg::PCE_DATA_W-1:0] pwdata, // Write data.
    output logic      [pce_pkg::PCE_DATA_W-1:0] prdata, // Read data.
    output logic                             pready,  // Transfer done.
    output logic                             pslverr  // Unmapped offset.
);
    import pce_pkg::*;

    // ********************************************************************
    // Declarations.
    // ********************************************************************
    logic             enableQ, enableD;        // Unit enable.
    logic             lsbFirstQ, lsbFirstD;    // Input bit order.
    logic [2:0]       widthSelQ, widthSelD;    // Checksum type.
    logic [31:0]      seedQ, seedD;            // Last seed written.
    logic [31:0]      stateQ, stateD;          // Running checksum.
    logic             preadyQ, preadyD;        // Bus completion.
    logic             pslverrQ, pslverrD;      // Bus error.
    logic [31:0]      prdataQ, prdataD;        // Bus read data.

    logic             access;                  // Access phase pending.
    logic             isCtrl, isWord, isHalf;  // Offset decode.
    logic             isByte, isRes, isSeed;   // Offset decode.
    logic             isPriv, isData, mapped;  // Offset decode.
    logic             dropData;                // Data write discarded.
    logic             needPush;                // Write goes to queue.
    logic             waitIdle;                // Access needs empty queue.
    logic             go;                      // Complete this access.
    logic [31:0]      resultView;              // Presented checksum.
    logic [31:0]      ctrlView;                // Control read value.
    logic [31:0]      readValue;               // Selected read value.
    pce_entry_s       pushEntry;               // Entry to enqueue.
    pce_entry_s       headEntry;               // Entry at queue head.
    logic [5:0]       headBits;                // Bits in head entry.
    logic [15:0]      fold16;                  // 16-bit step result.
    logic [31:0]      fold32;                  // 32-bit step result.
    logic             popNow;                  // Head consumed.

    pce_stream_if #(.W(ENTRY_W)) fillIf ();    // Bus to queue.
    pce_stream_if #(.W(ENTRY_W)) drainIf ();   // Queue to engine.

    // Mirror a 32-bit word end for end.
    function automatic logic [31:0] rev32(input logic [31:0] v);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31-i];
        end
        return r;
    endfunction

    // Mirror a 16-bit half end for end.
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    // ********************************************************************
    // Address decode and bus acceptance.
    // ********************************************************************

    // Decode the offset once; the private byte is mapped but inert.
    always_comb begin
        isCtrl = (paddr == OFF_CONTROL);
        isWord = (paddr == OFF_WORD);
        isHalf = (paddr == OFF_HALFWORD);
        isByte = (paddr == OFF_BYTE);
        isRes  = (paddr == OFF_RESULT);
        isSeed = (paddr == OFF_SEED);
        isPriv = (paddr == OFF_PRIVATE);
        isData = isWord | isHalf | isByte;
        mapped = isCtrl | isData | isRes | isSeed | isPriv;
    end

    // A data write is thrown away while the unit is held or the width
    // code is reserved, so only a seed write can move the running checksum then.
    always_comb begin
        dropData = ~enableQ | (widthSelQ != WSEL_CRC16 &&
                               widthSelQ != WSEL_CRC32);
        needPush = pwrite & ((isData & ~dropData) | isSeed);
    end

    // Control writes and checksum reads wait until every queued step has
    // landed, so the mode never changes under a pending word and a read
    // never shows a stale sum. The cost is a longer wait state.
    always_comb begin
        access   = psel & penable & ~preadyQ;
        waitIdle = (pwrite & isCtrl) | (~pwrite & (isRes | isData));
        go       = access & (~waitIdle | ~drainIf.valid)
                          & (~needPush | fillIf.ready);
    end

    // Enqueue the written word with its kind; ready stalls the bus.
    always_comb begin
        pushEntry.data = pwdata;
        if (isSeed) begin
            pushEntry.kind = KIND_SEED;
        end else if (isHalf) begin
            pushEntry.kind = KIND_HALF;
        end else if (isByte) begin
            pushEntry.kind = KIND_BYTE;
        end else begin
            pushEntry.kind = KIND_WORD;
        end
    end

    assign fillIf.valid = go & needPush;
    assign fillIf.data  = pushEntry;

    pce_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clk   (clk),
        .srst  (srst),
        .fill  (fillIf),
        .drain (drainIf)
    );

    // ********************************************************************
    // Read view and register writes.
    // ********************************************************************

    // The result is mirrored back in LSB-first mode; no complement.
    always_comb begin
        if (widthSelQ == WSEL_CRC32) begin
            resultView = lsbFirstQ ? rev32(stateQ) : stateQ;
        end else begin
            resultView = {16'h0000, lsbFirstQ ? rev16(stateQ[15:0])
                                              : stateQ[15:0]};
        end
    end

    // Reserved control bits always read back as zero.
    always_comb begin
        ctrlView = ZERO_WORD;
        ctrlView[CTL_ENABLE_BIT] = enableQ;
        ctrlView[CTL_ORDER_BIT]  = lsbFirstQ;
        ctrlView[CTL_WSEL_HI:CTL_WSEL_LO] = widthSelQ;
    end

    // Select the word a read returns.
    always_comb begin
        if (isCtrl) begin
            readValue = ctrlView;
        end else if (isData | isRes) begin
            readValue = resultView;
        end else if (isSeed) begin
            readValue = seedQ;
        end else begin
            readValue = ZERO_WORD;
        end
    end

    // Bus answer and register updates, all taken in the completing cycle.
    always_comb begin
        preadyD   = go;
        pslverrD  = go & ~mapped;
        prdataD   = (go & ~pwrite) ? readValue : ZERO_WORD;
        enableD   = enableQ;
        lsbFirstD = lsbFirstQ;
        widthSelD = widthSelQ;
        seedD     = seedQ;
        if (go & pwrite & isCtrl) begin
            enableD   = pwdata[CTL_ENABLE_BIT];
            lsbFirstD = pwdata[CTL_ORDER_BIT];
            widthSelD = pwdata[CTL_WSEL_HI:CTL_WSEL_LO];
        end
        if (go & pwrite & isSeed) begin
            seedD = pwdata;
        end
    end

    // ********************************************************************
    // Checksum engine.
    // ********************************************************************

    // Step size of the head entry; an empty queue reads as zeros.
    always_comb begin
        headEntry = pce_entry_s'(drainIf.valid ? drainIf.data : '0);
        unique case (headEntry.kind)
            KIND_WORD: headBits = BITS_WORD;
            KIND_HALF: headBits = BITS_HALF;
            KIND_BYTE: headBits = BITS_BYTE;
            KIND_SEED: headBits = 6'h00;
        endcase
    end

    pce_fold #(
        .CRC_W (16),
        .POLY  (POLY16)
    ) u_fold16 (
        .stateIn  (stateQ[15:0]),
        .dataIn   (headEntry.data),
        .nBits    (headBits),
        .stateOut (fold16)
    );

    pce_fold #(
        .CRC_W (32),
        .POLY  (POLY32)
    ) u_fold32 (
        .stateIn  (stateQ),
        .dataIn   (headEntry.data),
        .nBits    (headBits),
        .stateOut (fold32)
    );

    // The engine drains while enabled; seeds drain even when held so a
    // later control write can never wait on a queue that cannot empty.
    assign popNow        = drainIf.valid & drainIf.ready;
    assign drainIf.ready = enableQ | (headEntry.kind == KIND_SEED);

    // Each popped entry updates the state in one cycle; the state is not
    // cleared between words, so mixed widths simply accumulate.
    always_comb begin
        stateD = stateQ;
        if (popNow) begin
            if (headEntry.kind == KIND_SEED) begin
                if (widthSelQ == WSEL_CRC32) begin
                    stateD = lsbFirstQ ? rev32(headEntry.data)
                                       : headEntry.data;
                end else begin
                    stateD = {16'h0000, lsbFirstQ
                              ? rev16(headEntry.data[15:0])
                              : headEntry.data[15:0]};
                end
            end else if (widthSelQ == WSEL_CRC32) begin
                stateD = fold32;
            end else begin
                stateD = {16'h0000, fold16};
            end
        end
    end

    // ********************************************************************
    // State registers.
    // ********************************************************************

    // Register everything; control and seed reset to zero.
    always_ff @(posedge clk) begin
        if (srst) begin
            enableQ   <= 1'b0;
            lsbFirstQ <= 1'b0;
            widthSelQ <= WSEL_CRC16;
            seedQ     <= ZERO_WORD;
            stateQ    <= STATE_RESET;
            preadyQ   <= 1'b0;
            pslverrQ  <= 1'b0;
            prdataQ   <= ZERO_WORD;
        end else begin
            enableQ   <= enableD;
            lsbFirstQ <= lsbFirstD;
            widthSelQ <= widthSelD;
            seedQ     <= seedD;
            stateQ    <= stateD;
            preadyQ   <= preadyD;
            pslverrQ  <= pslverrD;
            prdataQ   <= prdataD;
        end
    end

    // Outputs come straight from flops.
    assign prdata  = prdataQ;
    assign pready  = preadyQ;
    assign pslverr = pslverrQ;

endmodule

`default_nettype wire

// ===== tb/pce_core_chk.sv
// Port checker for the checksum engine, bound to pce_core.
// Assumes APB3 timing as handed over: one-cycle registered answers.
`timescale 1ns/100ps
`default_nettype none
module pce_core_chk
    import pce_pkg::*;
(
    input wire logic        clk,     // System clock.
    input wire logic        srst,    // Sync reset.
    input wire logic        psel,    // Select.
    input wire logic        penable, // Access phase.
    input wire logic        pwrite,  // Write when high.
    input wire logic [7:0]  paddr,   // Byte offset.
    input wire logic [31:0] pwdata,  // Write data.
    input wire logic [31:0] prdata,  // Read data.
    input wire logic        pready,  // Transfer done.
    input wire logic        pslverr  // Unmapped offset.
);
    // ****************************************************************
    // Shadow of what software wrote and last saw.
    // ****************************************************************
    localparam int WAIT_MAX = 40;  // Covers a full queue drain.
    logic [31:0] ctlQ, ctlD, seedQ, seedD, resQ, resD; // Shadows.
    logic        cleanQ, cleanD;   // Result untouched since last read.
    logic        wrDone, rdRes;    // Finished write, checksum read.
    assign wrDone = pready && pwrite;
    assign rdRes = pready && !pwrite && paddr inside {8'h04, 8'h08,
        8'h0c, 8'h10};
    // Any write that may move the result view clears the clean flag.
    always_comb begin
        ctlD = (wrDone && paddr == OFF_CONTROL) ? pwdata : ctlQ;
        seedD = (wrDone && paddr == OFF_SEED) ? pwdata : seedQ;
        resD = rdRes ? prdata : resQ;
        cleanD = rdRes ? 1'b1 : cleanQ;
        if (wrDone && (paddr inside {OFF_CONTROL, OFF_SEED} || (ctlQ[0]
            && ctlQ[6:4] < 3'h2 && paddr inside {8'h04, 8'h08, 8'h0c})))
            cleanD = 1'b0;
    end
    // Registers only; reset mirrors the engine's own reset state.
    always_ff @(posedge clk) begin
        ctlQ <= srst ? ZERO_WORD : ctlD;
        seedQ <= srst ? ZERO_WORD : seedD;
        resQ <= srst ? STATE_RESET : resD;
        cleanQ <= srst ? 1'b1 : cleanD;
    end
    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    pulse_once_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    answer_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access phase");
    access_min_a: assert property (psel && $rose(penable) |-> !pready)
        else $error("pready in the first access cycle");
    answer_bound_a: assert property
        (psel && $rose(penable) |-> ##[1:WAIT_MAX] pready)
        else $error("access phase never answered");
    idle_zero_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside an answer");
    unmapped_err_a: assert property (pready |-> pslverr == !(paddr inside
        {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18}))
        else $error("error flag wrong for offset");
    ctl_readback_a: assert property
        (pready && !pwrite && paddr == OFF_CONTROL |->
        prdata == (ctlQ & 32'h00000075))
        else $error("control read back wrong");
    seed_readback_a: assert property
        (pready && !pwrite && paddr == OFF_SEED |-> prdata == seedQ)
        else $error("seed read back wrong");
    half_view_a: assert property
        (rdRes && ctlQ[6:4] != WSEL_CRC32 |-> prdata[31:16] == 16'h0)
        else $error("upper half set outside 32-bit mode");
    stale_view_a: assert property
        (rdRes && cleanQ |-> prdata == resQ)
        else $error("checksum moved without a counted write");
    private_zero_a: assert property
        (pready && !pwrite && paddr == OFF_PRIVATE |-> prdata == 32'h0)
        else $error("private byte not zero");
    wide_c: cover property (rdRes && ctlQ[6:4] == WSEL_CRC32);
    err_c: cover property (pready && pslverr);
    seed_c: cover property (wrDone && paddr == OFF_SEED);
endmodule
bind pce_core pce_core_chk chk (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ===== tb/pce_apb_host.sv
// Processor-side model: an APB3 master offering one transfer task.
// Assumes the bench calls xfer from one process only.
`timescale 1ns/100ps
`default_nettype none
module pce_apb_host (
    input  wire logic        clk,     // System clock.
    output logic             psel,    // Select.
    output logic             penable, // Access phase.
    output logic             pwrite,  // Direction.
    output logic [7:0]       paddr,   // Byte offset.
    output logic [31:0]      pwdata,  // Write data.
    input  wire logic [31:0] prdata,  // Read data.
    input  wire logic        pready,  // Transfer done.
    input  wire logic        pslverr  // Error answer.
);
    int hangs = 0; // Transfers cut short by the bound.
    // Bus idles from time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Setup, access, then hold until the edge that samples pready.
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge clk);
        #1;
        psel = 1'b1;
        pwrite = wr;
        paddr = a;
        pwdata = wd;
        @(posedge clk);
        #1;
        penable = 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) hangs++;
        rd = prdata;
        err = pslverr;
        #1;
        psel = 1'b0;
        penable = 1'b0;
        pwdata = ~wd; // A released bus shows no stale data.
    endtask
endmodule
`default_nettype wire

// ===== tb/parallel_crc_engine_bench.sv
// Self-checking bench: register sequences against a serial model.
// Assumes pce_core, pce_apb_host and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module parallel_crc_engine_bench;
    import pce_pkg::*;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr; // Pins.
    logic [7:0]  paddr;     // Offset.
    logic [31:0] pwdata, prdata, rd, ctl, refS; // Bus, model state.
    logic        err;       // Error seen.
    int          err_total = 0, n_checks = 0, cycles = 0; // Counters.
    string       msg = "123456789"; // Check vector text.
    logic [31:0] modes [4] = '{32'h01, 32'h05, 32'h11, 32'h15}; // Modes.
    pce_apb_host host (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    pce_core #(.QUEUE_DEPTH(FIFO_DEPTH)) dut (.clk(clk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Clock: 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // A hang is cut short well past the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            finish_test();
        end
    end
    function automatic logic [31:0] rev(input logic [31:0] v, input int w);
        logic [31:0] r = 32'h0;
        for (int i = 0; i < w; i++) r[i] = v[w-1-i];
        return r;
    endfunction
    // Bit order view; the same mapping loads the seed.
    function automatic logic [31:0] view(input logic [31:0] s);
        if (ctl[6:4] == WSEL_CRC32) return ctl[2] ? rev(s, 32) : s;
        return ctl[2] ? rev(s, 16) : {16'h0, s[15:0]};
    endfunction
    // Serial reference: data bit 0 enters the shift register first.
    function automatic logic [31:0] fold(input logic [31:0] s,
        input logic [31:0] d, input int n);
        logic w = (ctl[6:4] == WSEL_CRC32);
        for (int i = 0; i < n; i++)
            s = (s << 1) ^ (((w ? s[31] : s[15]) ^ d[i]) ?
                (w ? POLY32 : {16'h0, POLY16}) : 32'h0);
        return w ? s : {16'h0, s[15:0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            err_total++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
        check({31'h0, err}, {31'h0, a > 8'h18});
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd, err);
        check({31'h0, err}, {31'h0, a > 8'h18});
        check(rd, exp);
    endtask
    task automatic dat(input logic [7:0] a, input logic [31:0] d);
        wr(a, d);
        if (ctl[0] && ctl[6:4] < 3'h2)
            refS = fold(refS, d, a == OFF_WORD ? 32 : a == OFF_BYTE ? 8 : 16);
    endtask
    task automatic ctrl(input logic [31:0] v);
        wr(OFF_CONTROL, v);
        ctl = v & 32'h00000075;
    endtask
    task automatic finish_test();
        check(32'(host.hangs), 32'h0);
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence; its reset part runs twice so a mid-run reset is covered.
    initial begin
        for (int pass = 0; pass < 2; pass++) begin
            srst = 1'b1;
            ctl = 32'h0;
            refS = STATE_RESET;
            repeat (12) @(posedge clk);
            #1 srst = 1'b0;
            rdx(OFF_CONTROL, 32'h0);
            rdx(OFF_RESULT, STATE_RESET);
            rdx(OFF_BYTE, STATE_RESET);
            rdx(OFF_SEED, 32'h0);
            rdx(OFF_PRIVATE, 32'h0);
            rdx(8'h1c, 32'h0);
            wr(OFF_RESULT, 32'h12345678);
            rdx(OFF_RESULT, STATE_RESET);
            ctrl(32'hffffffff);
            rdx(OFF_CONTROL, 32'h75);
            dat(OFF_WORD, 32'h11223344);
            rdx(OFF_RESULT, view(refS));
            ctrl(32'h14);
            dat(OFF_BYTE, 32'h5a);
            rdx(OFF_RESULT, view(refS));
            $display("test reset_and_drops done");
        end
        foreach (modes[i]) begin
            ctrl(modes[i]);
            wr(OFF_SEED, 32'hc3a51e0f ^ i);
            refS = view(32'hc3a51e0f ^ i);
            dat(OFF_WORD, 32'h04030201);
            dat(OFF_HALFWORD, 32'hdead0605);
            dat(OFF_BYTE, 32'hbeefff07);
            rdx(OFF_HALFWORD, view(refS));
            rdx(OFF_RESULT, view(refS));
            rdx(OFF_SEED, 32'hc3a51e0f ^ i);
        end
        $display("test mixed_widths done");
        ctrl(32'h15);
        wr(OFF_SEED, 32'hffffffff);
        for (int i = 0; i < msg.len(); i++)
            wr(OFF_BYTE, {24'ha5a5a5, msg[i]});
        rdx(OFF_RESULT, ~32'hcbf43926);
        $display("test check_vector done");
        finish_test();
    end
endmodule
`default_nettype wire
